// ### hdl/acs_consts.svh
// Constants for the channel, status, interrupt and result registers of the
// eight-channel converter control block. Included by the package and the block.
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_ADDR_W 8
`define ACS_OFF_CHAN_SET 8'h10
`define ACS_OFF_CHAN_CLEAR 8'h14
`define ACS_OFF_CHAN_STATE 8'h18
`define ACS_OFF_STATUS 8'h1C
`define ACS_OFF_LATEST 8'h20
`define ACS_OFF_IRQ_SET 8'h24
`define ACS_OFF_IRQ_CLEAR 8'h28
`define ACS_OFF_IRQ_MASK 8'h2C
`define ACS_OFF_CHAN_RES0 8'h30
`define ACS_OFF_CHAN_RES7 8'h4C

`define ACS_BIT_OVR_LO 8
`define ACS_BIT_RESULT_AVAILABLE_FLAG 16
`define ACS_BIT_GOVR 17
`define ACS_BIT_DMA_COUNT_REACHED_ZERO 18
`define ACS_BIT_DMA_BUFFERS_EXHAUSTED 19

`define ACS_RST_CHAN_STATE 8'h00
`define ACS_RST_IRQ_MASK 20'h00000
`define ACS_RST_RESULT 10'h000

`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

`endif

// ### hdl/acs_pkg.sv
// Types shared by the converter control block and whoever binds to it.
// Assumes the constants header sits beside it on the include path.
package acs_pkg;
  `include "acs_consts.svh"

  localparam int ACS_NCH = 8;
  localparam int ACS_RES_W = 10;
  localparam int ACS_FLAGS_W = 20;

  typedef enum logic [1:0] {
    ACS_SEQ_IDLE,
    ACS_SEQ_ISSUE,
    ACS_SEQ_WAIT
  } acs_seq_t;

  // One beat handed to the peripheral DMA: channel number and its result.
  typedef struct packed {
    logic [2:0] chan;
    logic [9:0] data;
  } acs_beat_t;

  // Request to the analog cell: convert this channel.
  typedef struct packed {
    logic start;
    logic [2:0] chan;
  } acs_conv_req_t;

  // Whole state of the block, registered as one word.
  typedef struct packed {
    acs_seq_t seq;
    logic [2:0] seq_chan;
    logic [7:0] chan_en;
    logic [7:0] eoc;
    logic [7:0] ovr;
    logic result_available_flag;
    logic govr;
    logic dma_count_reached_zero;
    logic [19:0] imask;
    logic [9:0] latest;
    logic [7:0][9:0] chan_res;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    acs_conv_req_t conv;
    logic dma_valid;
    acs_beat_t dma_beat;
  } acs_state_t;
endpackage

// ### hdl/acs_regs.sv
// Channel control, status, interrupt mask and result holding for an
// eight-channel converter, with its conversion sequencer and DMA beat port.
// Assumes one clock, a synchronous analog cell that returns one done pulse
// per start request, and a DMA engine that reports its counter state.
//
// How it works
// - Write one to channel-set bits 0..7 enables that channel; zeros ignored.
// - Write one to channel-clear bits 0..7 disables that channel; zeros ignored.
// - Channel-state bits 0..7 read one for each enabled channel.
// - Status bits 0..7 read one only for enabled channels with finished conversion.
// - Status bits 8..15 record channel overruns since last status read; read clears.
// - Status bit 16 sets on a new latest result; reading latest result clears it.
// - Status bit 17 records a general overrun; status read clears it.
// - Status bit 18 sets when DMA current count hits zero since counter write.
// - Status bit 19 reads one while both DMA counts are zero.
// - Latest-result bits 9..0 capture each completed conversion and hold.
// - Per-channel result loads only while its channel is enabled, then holds.
// - Write one to irq-set bits 0..19 enables that flag's interrupt.
// - Write one to irq-clear bits 0..19 disables that flag's interrupt.
// - Irq-mask view reads the enabled interrupts in status layout.
// - DMA receives results only from enabled channels, in channel order.
// - One start request converts every enabled channel in turn, then waits.
`timescale 1ns/10ps

`include "acs_consts.svh"

module acs_regs
  import acs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // AXI4-Lite slave.
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [7:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // Conversion trigger and analog cell.
  input wire logic i_start,
  output acs_conv_req_t o_conv_req,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_data,
  // Peripheral DMA.
  output logic o_dma_valid,
  input wire logic i_dma_ready,
  output acs_beat_t o_dma_beat,
  input wire logic i_dma_cur_zero,
  input wire logic i_dma_next_zero,
  input wire logic i_dma_count_write,
  // Interrupt and sequencer state.
  output logic o_irq,
  output logic o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Lowest enabled channel at or above the given index; bit 3 flags a find.
  function automatic logic [3:0] acs_next_chan(input logic [7:0] en, input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && (4'(i) >= from)) begin
        res = {1'b1, 3'(i)};
      end
    end
    return res;
  endfunction

  function automatic logic acs_mapped(input logic [7:0] a);
    return (a >= `ACS_OFF_CHAN_SET) && (a <= `ACS_OFF_CHAN_RES7) && (a[1:0] == 2'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  acs_state_t s_ff;
  acs_state_t nxt_s;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [19:0] status;
  logic dma_buffers_exhausted;
  logic [3:0] pick;
  logic [2:0] rd_ch;
  logic aw_take;
  logic w_take;
  logic wr_commit;
  logic rd_take;
  logic dma_take;
  logic rd_hit_result;
  logic [7:0] done_view;
  logic [19:0] irq_src;
  logic [31:0] rd_word;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_strb
      assign wmask[g*8 +: 8] = {8{i_s_axi_wstrb[g]}};
    end
  endgenerate

  // Handshake events, named once so the next-state logic reads as a list of effects.
  assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
  assign w_take = i_s_axi_wvalid && o_s_axi_wready;
  assign wr_commit = s_ff.aw_got && s_ff.w_got && !s_ff.bvalid;
  assign rd_take = i_s_axi_arvalid && o_s_axi_arready;
  assign dma_take = s_ff.dma_valid && i_dma_ready;

  // Result registers sit at consecutive words, so the word index picks the channel.
  assign rd_ch = i_s_axi_araddr[4:2] - 3'h4;
  assign rd_hit_result = acs_mapped(i_s_axi_araddr) && (i_s_axi_araddr >= `ACS_OFF_CHAN_RES0);

  generate
    for (g = 0; g < 8; g++) begin : g_done
      // A disabled channel hides its done flag even if one was left over.
      assign done_view[g] = s_ff.eoc[g] & s_ff.chan_en[g];
    end
  endgenerate

  assign dma_buffers_exhausted = i_dma_cur_zero & i_dma_next_zero;
  assign status = {dma_buffers_exhausted, s_ff.dma_count_reached_zero, s_ff.govr, s_ff.result_available_flag, s_ff.ovr, done_view};
  assign irq_src = status & s_ff.imask;

  assign o_s_axi_awready = !s_ff.aw_got && !s_ff.bvalid;
  assign o_s_axi_wready = !s_ff.w_got && !s_ff.bvalid;
  assign o_s_axi_arready = !s_ff.rvalid;
  assign o_s_axi_bvalid = s_ff.bvalid;
  assign o_s_axi_bresp = s_ff.bresp;
  assign o_s_axi_rvalid = s_ff.rvalid;
  assign o_s_axi_rdata = s_ff.rdata;
  assign o_s_axi_rresp = s_ff.rresp;
  assign o_conv_req = s_ff.conv;
  assign o_dma_valid = s_ff.dma_valid;
  assign o_dma_beat = s_ff.dma_beat;
  assign o_busy = (s_ff.seq != ACS_SEQ_IDLE);
  assign o_irq = |irq_src;

  ////////////////////////////////////////////////////////////////////////////
  // Read data.
  //
  // Word map, byte addresses:
  //   0x10 channel set, write only, reads zero.
  //   0x14 channel clear, write only, reads zero.
  //   0x18 channel state.
  //   0x1C status; the read clears the overrun flags.
  //   0x20 latest result; the read clears data ready.
  //   0x24 and 0x28 interrupt set and clear, write only, read zero.
  //   0x2C interrupt mask view.
  //   0x30 to 0x4C per-channel results; a read clears that channel's done flag.
  // Everything else answers with an error and zero data.
  // The word is built from the current state, so a flag set in the same cycle
  // as its clearing read is seen on the next read rather than lost.

  always_comb begin
    rd_word = 32'h00000000;
    case (i_s_axi_araddr)
      `ACS_OFF_CHAN_SET: begin
        rd_word = 32'h00000000;
      end
      `ACS_OFF_CHAN_CLEAR: begin
        rd_word = 32'h00000000;
      end
      `ACS_OFF_IRQ_SET: begin
        rd_word = 32'h00000000;
      end
      `ACS_OFF_IRQ_CLEAR: begin
        rd_word = 32'h00000000;
      end
      `ACS_OFF_CHAN_STATE: begin
        rd_word = {24'h000000, s_ff.chan_en};
      end
      `ACS_OFF_STATUS: begin
        rd_word = {12'h000, status};
      end
      `ACS_OFF_LATEST: begin
        rd_word = {22'h00000, s_ff.latest};
      end
      `ACS_OFF_IRQ_MASK: begin
        rd_word = {12'h000, s_ff.imask};
      end
      default: begin
        if (rd_hit_result) begin
          rd_word = {22'h00000, s_ff.chan_res[rd_ch]};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    nxt_s = s_ff;
    nxt_s.conv.start = 1'b0;
    wbits = s_ff.wdata & wmask;
    pick = 4'h0;

    // Write channels: address and data are caught in either order.
    if (aw_take) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.aw_addr = i_s_axi_awaddr;
    end
    if (w_take) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = i_s_axi_wdata;
    end
    if (s_ff.bvalid && i_s_axi_bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (wr_commit) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = acs_mapped(s_ff.aw_addr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      case (s_ff.aw_addr)
        `ACS_OFF_CHAN_SET: begin
          nxt_s.chan_en = s_ff.chan_en | wbits[7:0];
        end
        `ACS_OFF_CHAN_CLEAR: begin
          nxt_s.chan_en = s_ff.chan_en & ~wbits[7:0];
        end
        `ACS_OFF_IRQ_SET: begin
          nxt_s.imask = s_ff.imask | wbits[19:0];
        end
        `ACS_OFF_IRQ_CLEAR: begin
          nxt_s.imask = s_ff.imask & ~wbits[19:0];
        end
        default: begin
        end
      endcase
    end

    // Read channel: data and read side effects are taken at the address handshake.
    if (s_ff.rvalid && i_s_axi_rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_word;
      nxt_s.rresp = acs_mapped(i_s_axi_araddr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      case (i_s_axi_araddr)
        `ACS_OFF_STATUS: begin
          nxt_s.ovr = 8'h00;
          nxt_s.govr = 1'b0;
        end
        `ACS_OFF_LATEST: begin
          nxt_s.result_available_flag = 1'b0;
        end
        default: begin
          if (rd_hit_result) begin
            nxt_s.eoc[rd_ch] = 1'b0;
          end
        end
      endcase
    end

    // The DMA taking a beat consumes the latest result as a software read would.
    if (dma_take) begin
      nxt_s.dma_valid = 1'b0;
      nxt_s.result_available_flag = 1'b0;
    end

    // A disabled channel never shows a finished conversion.
    nxt_s.eoc = nxt_s.eoc & nxt_s.chan_en;

    // Counter write clears; reaching zero in the same cycle still wins.
    if (i_dma_count_write) begin
      nxt_s.dma_count_reached_zero = 1'b0;
    end
    if (i_dma_cur_zero) begin
      nxt_s.dma_count_reached_zero = 1'b1;
    end

    // Sequencer. Hardware events come last so a set beats a same-cycle clear.
    case (s_ff.seq)
      ACS_SEQ_IDLE: begin
        pick = acs_next_chan(s_ff.chan_en, 4'h0);
        if (i_start && pick[3]) begin
          nxt_s.seq = ACS_SEQ_ISSUE;
          nxt_s.seq_chan = pick[2:0];
        end
      end
      ACS_SEQ_ISSUE: begin
        nxt_s.conv.start = 1'b1;
        nxt_s.conv.chan = s_ff.seq_chan;
        nxt_s.seq = ACS_SEQ_WAIT;
      end
      ACS_SEQ_WAIT: begin
        if (i_conv_done) begin
          nxt_s.latest = i_conv_data;
          if (s_ff.result_available_flag) begin
            nxt_s.govr = 1'b1;
          end
          nxt_s.result_available_flag = 1'b1;
          if (s_ff.chan_en[s_ff.seq_chan]) begin
            nxt_s.chan_res[s_ff.seq_chan] = i_conv_data;
            if (s_ff.eoc[s_ff.seq_chan]) begin
              nxt_s.ovr[s_ff.seq_chan] = 1'b1;
            end
            nxt_s.eoc[s_ff.seq_chan] = 1'b1;
            // Without a buffer an unclaimed beat is replaced; overrun flags show it.
            nxt_s.dma_valid = 1'b1;
            nxt_s.dma_beat.chan = s_ff.seq_chan;
            nxt_s.dma_beat.data = i_conv_data;
          end
          pick = (s_ff.seq_chan == 3'h7) ? 4'h0 :
                 acs_next_chan(s_ff.chan_en, {1'b0, s_ff.seq_chan} + 4'h1);
          if (pick[3]) begin
            nxt_s.seq = ACS_SEQ_ISSUE;
            nxt_s.seq_chan = pick[2:0];
          end else begin
            nxt_s.seq = ACS_SEQ_IDLE;
          end
        end
      end
      default: begin
        nxt_s.seq = ACS_SEQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_ff <= '0;
      s_ff.chan_en <= `ACS_RST_CHAN_STATE;
      s_ff.imask <= `ACS_RST_IRQ_MASK;
      s_ff.latest <= `ACS_RST_RESULT;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule // acs_regs

// ### dv/acs_regs_sva.sv
// Port assertions for the converter control block, bound to acs_regs.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps

module acs_regs_sva
  import acs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic [7:0] i_s_axi_araddr,
  input wire logic o_s_axi_rvalid,
  input wire logic [31:0] o_s_axi_rdata,
  input wire acs_conv_req_t o_conv_req,
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_data,
  input wire logic o_dma_valid,
  input wire logic i_dma_ready,
  input wire acs_beat_t o_dma_beat,
  input wire logic i_dma_cur_zero,
  input wire logic i_dma_next_zero,
  input wire logic o_busy
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  write_resp_a: assert property (
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |-> ##2 o_s_axi_bvalid)
    else $error("write answer missing");
  read_resp_a: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read answer missing");
  dma_buffers_exhausted_read_a: assert property (
    i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == 8'h1C
    |=> o_s_axi_rdata[19] == $past(i_dma_cur_zero && i_dma_next_zero))
    else $error("buffers-exhausted flag wrong");
  seq_start_a: assert property (
    $rose(o_busy) |=> o_conv_req.start) else $error("sequence did not start");
  start_busy_a: assert property (
    o_conv_req.start |-> o_busy) else $error("conversion while idle");
  start_pulse_a: assert property (
    o_conv_req.start |=> !o_conv_req.start) else $error("start longer than one cycle");
  dma_hold_a: assert property (
    o_dma_valid && !i_dma_ready && !i_conv_done |=> o_dma_valid && $stable(o_dma_beat))
    else $error("beat dropped or changed");
  dma_data_a: assert property (
    i_conv_done |=> o_dma_valid && o_dma_beat.data == $past(i_conv_data))
    else $error("beat data wrong");
endmodule // acs_regs_sva

bind acs_regs acs_regs_sva chk_u (
  .i_core_clk, .i_sys_rst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
  .o_s_axi_wready, .o_s_axi_bvalid, .i_s_axi_arvalid, .o_s_axi_arready, .i_s_axi_araddr,
  .o_s_axi_rvalid, .o_s_axi_rdata, .o_conv_req, .i_conv_done, .i_conv_data, .o_dma_valid,
  .i_dma_ready, .o_dma_beat, .i_dma_cur_zero, .i_dma_next_zero, .o_busy
);

// ### dv/acs_cell_model.sv
// Behavioural analog cell and DMA sink for the converter control block.
// Assumes one start pulse per conversion; the DMA side takes a beat every other cycle.
`timescale 1ns/10ps

module acs_cell_model
  import acs_pkg::*;
#(parameter int LAT = 3)
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire acs_conv_req_t i_req,
  output logic o_done,
  output logic [9:0] o_data,
  output logic o_ready
);
  logic [3:0] cnt_ff;
  logic [2:0] chan_ff;
  ////////////////////////////////////////
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cnt_ff <= 4'h0;
      chan_ff <= 3'h0;
      o_ready <= 1'b0;
    end else begin
      o_ready <= ~o_ready;
      if (i_req.start) begin
        cnt_ff <= 4'(LAT);
        chan_ff <= i_req.chan;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
  assign o_done = cnt_ff == 4'h1;
  // Outside the done pulse the bus shows garbage, so a late sample is caught.
  assign o_data = o_done ? {chan_ff, 7'h15} : ~{chan_ff, 7'h15};
endmodule // acs_cell_model

// ### dv/acs_regs_tb.sv
// Self-checking bench for acs_regs over AXI4-Lite, with the cell model as far side.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/10ps

module acs_regs_tb;
  import acs_pkg::*;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_start = 1'b0, i_s_axi_bready = 1'b1;
  logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_arvalid = 1'b0;
  logic i_s_axi_rready = 1'b1, i_dma_cur_zero = 1'b0, i_dma_next_zero = 1'b0;
  logic i_dma_count_write = 1'b0;
  logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
  logic [31:0] i_s_axi_wdata = 32'h00000000, o_s_axi_rdata;
  logic [3:0] i_s_axi_wstrb = 4'hF;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
  logic i_conv_done, i_dma_ready, o_dma_valid, o_irq, o_busy;
  logic [9:0] i_conv_data;
  acs_conv_req_t o_conv_req;
  acs_beat_t o_dma_beat;
  int fail_count = 0;
  int cmp_count = 0;
  ////////////////////////////////////////
  acs_regs dut_u (.*);
  acs_cell_model cell_u (.i_core_clk, .i_sys_rst, .i_req(o_conv_req), .o_done(i_conv_done),
    .o_data(i_conv_data), .o_ready(i_dma_ready));
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end
  ////////////////////////////////////////
  task automatic finish_test();
    $display("compared %0d, mismatched %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge i_core_clk);
    n++;
    if (n > 200) begin
      fail_count++;
      finish_test();
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    do begin
      tick(n);
      if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
      if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
    end while (!o_s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    do begin
      tick(n);
      if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
    end while (!o_s_axi_rvalid);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d & m);
  endtask
  task automatic run_seq();
    int n;
    n = 0;
    i_start <= 1'b1;
    @(posedge i_core_clk);
    i_start <= 1'b0;
    do tick(n); while (o_busy);
  endtask
  ////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (20) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    rc("chan_state", 8'h18, 32'hFFFFFFFF, 32'h00000000);
    rc("irq_mask", 8'h2C, 32'hFFFFFFFF, 32'h00000000);
    wr(8'h10, 32'h0000FFA5);
    rc("chan_state", 8'h18, 32'hFFFFFFFF, 32'h000000A5);
    wr(8'h14, 32'h00000081);
    rc("chan_state", 8'h18, 32'hFFFFFFFF, 32'h00000024);
    wr(8'h24, 32'hFFFFFFFF);
    rc("irq_mask", 8'h2C, 32'hFFFFFFFF, 32'h000FFFFF);
    wr(8'h28, 32'h000FFFF0);
    rc("irq_mask", 8'h2C, 32'hFFFFFFFF, 32'h0000000F);
    chk("irq", 32'h0, {31'h0, o_irq});
    $display("test registers done");
    // Enables are left alone while the sequence runs.
    run_seq();
    rc("status", 8'h1C, 32'h0000FFFF, 32'h00000024);
    chk("irq", 32'h1, {31'h0, o_irq});
    rc("res0", 8'h30, 32'hFFFFFFFF, 32'h00000000);
    rc("res2", 8'h38, 32'hFFFFFFFF, 32'h00000115);
    rc("latest", 8'h20, 32'hFFFFFFFF, 32'h00000295);
    chk("irq", 32'h0, {31'h0, o_irq});
    rc("result_available_flag", 8'h1C, 32'h00010000, 32'h00000000);
    run_seq();
    rc("status", 8'h1C, 32'h0000FFFF, 32'h00002024);
    rc("status", 8'h1C, 32'h0000FFFF, 32'h00000024);
    wr(8'h14, 32'h00000020);
    rc("eoc", 8'h1C, 32'h000000FF, 32'h00000004);
    $display("test conversions done");
    for (int i = 0; i < 4; i++) begin
      i_dma_cur_zero <= i[0];
      i_dma_next_zero <= i[1];
      i_dma_count_write <= 1'b1;
      @(posedge i_core_clk);
      i_dma_count_write <= 1'b0;
      rc("dma_buffers_exhausted", 8'h1C, 32'h00080000, {12'h000, i[0] & i[1], 19'h00000});
      rc("dma_count_reached_zero", 8'h1C, 32'h00040000, {13'h0000, i[0], 18'h00000});
    end
    rd(8'h80, d, r);
    chk("bad_data", 32'h00000000, d);
    chk("bad_resp", 32'h00000002, {30'h0, r});
    $display("test dma flags done");
    finish_test();
  end
endmodule // acs_regs_tb
